/* src/smh_countdown.sv */
// Loadable down-counter stepped by a tick enable.
`timescale 1ns/1ps
module smh_countdown #(
	parameter int W = 21
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic load_in,
	input wire logic [W-1:0] value_in,
	input wire logic run_in,
	input wire logic tick_in,
	output logic zero_out
);
	logic [W-1:0] count_q;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			count_q <= '0;
		end else if (load_in) begin
			count_q <= value_in;
		end else if (run_in && tick_in && count_q != '0) begin
			count_q <= count_q - 1'b1;
		end
	end

	assign zero_out = (count_q == '0);
endmodule

/* src/smh_handler.sv */
// Reliability subcommand handler with a task file on classic Wishbone.
//
// Decided for this implementation: the Wishbone slave port and the register addresses.
`timescale 1ns/1ps
module smh_handler #(
	parameter int TICK_CYCLES_P = smh_pkg::TICK_CYCLES,
	parameter int AUTOSAVE_TICKS_P = smh_pkg::AUTOSAVE_TICKS,
	parameter int OFFLINE_TICKS_P = smh_pkg::OFFLINE_TICKS,
	parameter int SHORT_TEST_TICKS_P = smh_pkg::SHORT_TEST_TICKS,
	parameter int EXT_TEST_TICKS_P = smh_pkg::EXT_TEST_TICKS
) (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic WB_WE_IN,
	input wire logic [7:0] WB_ADR_IN,
	input wire logic [3:0] WB_SEL_IN,
	input wire logic [31:0] WB_DAT_IN,
	output logic [31:0] WB_DAT_OUT,
	output logic WB_ACK_OUT,
	input wire logic NV_MON_EN_IN,
	input wire logic NV_AUTOSAVE_IN,
	input wire logic ACTIVE_IDLE_IN,
	input wire logic TEST_FAIL_IN,
	input wire logic PREFAIL_EXCEEDED_IN,
	output logic INTRQ_OUT,
	output logic ATTR_SAVE_OUT,
	output logic MON_EN_OUT,
	output logic AUTOSAVE_EN_OUT,
	output logic ROUTINE_RUN_OUT
);
	import smh_pkg::*;

	// ====================================================================
	// Pin inputs
	logic [NUM_PINS-1:0] pins_raw;
	logic [NUM_PINS-1:0] pins_s;
	logic nv_mon_s;
	logic nv_as_s;
	logic idle_s;
	logic fail_s;
	logic prefail_s;

	assign pins_raw = {PREFAIL_EXCEEDED_IN, TEST_FAIL_IN, ACTIVE_IDLE_IN,
		NV_AUTOSAVE_IN, NV_MON_EN_IN};
	assign {prefail_s, fail_s, idle_s, nv_as_s, nv_mon_s} = pins_s;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_sync
			smh_sync3 u_sync (
				.clk_in(CLOCK_IN),
				.rst_in(RST_IN),
				.pin_in(pins_raw[gi]),
				.level_out(pins_s[gi])
			);
		end
	endgenerate

	// ====================================================================
	// State
	smh_state_type state_q;
	logic ack_q;
	logic [7:0] feat_q;
	logic [7:0] seccnt_q;
	logic [7:0] secnum_q;
	logic [7:0] cyllo_q;
	logic [7:0] cylhi_q;
	logic [7:0] devhead_q;
	logic [7:0] cmd_q;
	logic busy_q;
	logic drq_q;
	logic err_q;
	logic abt_q;
	logic intrq_q;
	logic mon_q;
	logic autosave_q;
	logic save_q;
	logic routine_q;
	logic routine_test_q;
	logic [7:0] test_stat_q;
	logic [7:0] log_q;
	logic [8:0] ptr_q;
	logic [2:0] start_cnt_q;
	logic nv_loaded_q;
	logic idle_d_q;
	logic idle_seen_q;
	logic rt_load_q;
	logic [TMR_W-1:0] rt_val_q;
	logic as_load_q;
	logic [DIV_W-1:0] div_q;
	logic tick_q;
	logic [7:0] vend_mem [0:VEND_BYTES-1];

	// ====================================================================
	// Bus decode
	logic req;
	logic wr;
	logic rd;
	logic [5:0] idx;
	logic cmd_wr;
	logic st_rd;
	logic dat_acc;
	logic as_en;
	logic rt_zero;
	logic as_zero;
	logic rt_run;
	logic [7:0] status_byte;
	logic [7:0] log_byte;
	logic log_vend;
	logic log_valid;

	assign req = WB_CYC_IN && WB_STB_IN && !ack_q;
	assign idx = WB_ADR_IN[7:2];
	assign wr = req && WB_WE_IN && WB_SEL_IN[0];
	assign rd = req && !WB_WE_IN;
	assign cmd_wr = wr && idx == IDX_CMD;
	assign st_rd = rd && idx == IDX_CMD;
	assign dat_acc = idx == IDX_DATA && ((state_q == ST_RDX && rd) || (state_q == ST_WRX && wr));
	assign as_en = mon_q && autosave_q;
	assign rt_run = (routine_q && state_q == ST_IDLE) || state_q == ST_CAPT;
	// Ready stays set at all times, so a background routine never clears it.
	assign status_byte = {busy_q, 1'b1, 1'b0, 1'b1, drq_q, 1'b0, 1'b0, err_q};
	assign log_vend = secnum_q >= LOG_VEND_LO && secnum_q <= LOG_VEND_HI;
	assign log_valid = log_vend || secnum_q == LOG_ERROR || secnum_q == LOG_SELFTEST;

	always_comb begin
		log_byte = 8'h00;
		if (log_q >= LOG_VEND_LO) begin
			log_byte = vend_mem[{log_q[4:0], ptr_q}];
		end else if (log_q == LOG_SELFTEST && ptr_q == 9'h000) begin
			log_byte = test_stat_q;
		end
	end

	// ====================================================================
	// Wishbone slave: one wait state, unmapped reads return zero.
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			ack_q <= 1'b0;
			WB_DAT_OUT <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			if (rd) begin
				case (idx)
					IDX_DATA: WB_DAT_OUT <= {24'h00_0000, state_q == ST_RDX ? log_byte : 8'h00};
					IDX_FEAT: WB_DAT_OUT <= {24'h00_0000, 5'h00, abt_q, 2'h0};
					IDX_SECCNT: WB_DAT_OUT <= {24'h00_0000, seccnt_q};
					IDX_SECNUM: WB_DAT_OUT <= {24'h00_0000, secnum_q};
					IDX_CYLLO: WB_DAT_OUT <= {24'h00_0000, cyllo_q};
					IDX_CYLHI: WB_DAT_OUT <= {24'h00_0000, cylhi_q};
					IDX_DEVHEAD: WB_DAT_OUT <= {24'h00_0000, devhead_q};
					IDX_CMD: WB_DAT_OUT <= {24'h00_0000, status_byte};
					IDX_STATE: WB_DAT_OUT <= {28'h000_0000, routine_test_q, routine_q,
						autosave_q, mon_q};
					IDX_TESTSTAT: WB_DAT_OUT <= {24'h00_0000, test_stat_q};
					default: WB_DAT_OUT <= 32'h0000_0000;
				endcase
			end
		end
	end

	assign WB_ACK_OUT = ack_q;

	// Host vendor log sectors.
	always_ff @(posedge CLOCK_IN) begin
		if (dat_acc && state_q == ST_WRX) begin
			vend_mem[{log_q[4:0], ptr_q}] <= WB_DAT_IN[7:0];
		end
	end

	// ====================================================================
	// Millisecond tick and timers
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			div_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= div_q == DIV_W'(TICK_CYCLES_P - 1);
			div_q <= (div_q == DIV_W'(TICK_CYCLES_P - 1)) ? '0 : div_q + 1'b1;
		end
	end

	smh_countdown #(.W(TMR_W)) u_routine_tmr (
		.clk_in(CLOCK_IN),
		.rst_in(RST_IN),
		.load_in(rt_load_q),
		.value_in(rt_val_q),
		.run_in(rt_run),
		.tick_in(tick_q),
		.zero_out(rt_zero)
	);

	smh_countdown #(.W(TMR_W)) u_autosave_tmr (
		.clk_in(CLOCK_IN),
		.rst_in(RST_IN),
		.load_in(as_load_q),
		.value_in(TMR_W'(AUTOSAVE_TICKS_P)),
		.run_in(as_en),
		.tick_in(tick_q),
		.zero_out(as_zero)
	);

	// ====================================================================
	// Persistent enables and background saves
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			start_cnt_q <= 3'h0;
			nv_loaded_q <= 1'b0;
			idle_d_q <= 1'b0;
			idle_seen_q <= 1'b0;
			as_load_q <= 1'b1;
		end else begin
			idle_d_q <= idle_s;
			if (!nv_loaded_q) begin
				start_cnt_q <= start_cnt_q + 1'b1;
				nv_loaded_q <= start_cnt_q == NV_LOAD_CYCLE;
			end
			if (as_en && idle_s && !idle_d_q) begin
				idle_seen_q <= 1'b1;
			end
			// Reload after every save so the interval runs from the last one.
			as_load_q <= !as_en || save_q;
		end
	end

	// ====================================================================
	// Command engine
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			state_q <= ST_IDLE;
			feat_q <= RST_TASK;
			seccnt_q <= RST_TASK;
			secnum_q <= RST_TASK;
			cyllo_q <= RST_TASK;
			cylhi_q <= RST_TASK;
			devhead_q <= RST_TASK;
			cmd_q <= RST_TASK;
			busy_q <= 1'b0;
			drq_q <= 1'b0;
			err_q <= 1'b0;
			abt_q <= 1'b0;
			intrq_q <= 1'b0;
			mon_q <= 1'b0;
			autosave_q <= 1'b0;
			save_q <= 1'b0;
			routine_q <= 1'b0;
			routine_test_q <= 1'b0;
			test_stat_q <= TEST_PASS;
			log_q <= RST_TASK;
			ptr_q <= 9'h000;
			rt_load_q <= 1'b0;
			rt_val_q <= '0;
		end else begin
			save_q <= 1'b0;
			rt_load_q <= 1'b0;
			if (st_rd) begin
				intrq_q <= 1'b0;
			end
			if (wr && !busy_q && !drq_q) begin
				case (idx)
					IDX_FEAT: feat_q <= WB_DAT_IN[7:0];
					IDX_SECCNT: seccnt_q <= WB_DAT_IN[7:0];
					IDX_SECNUM: secnum_q <= WB_DAT_IN[7:0];
					IDX_CYLLO: cyllo_q <= WB_DAT_IN[7:0];
					IDX_CYLHI: cylhi_q <= WB_DAT_IN[7:0];
					IDX_DEVHEAD: devhead_q <= WB_DAT_IN[7:0];
					default: ;
				endcase
			end
			// Enables are restored from the nonvolatile store once after reset.
			if (!nv_loaded_q && start_cnt_q == NV_LOAD_CYCLE) begin
				mon_q <= nv_mon_s;
				// Autosave never comes back on without monitoring, whatever the store holds.
				autosave_q <= nv_as_s && nv_mon_s;
			end
			if (as_en && !save_q && ((idle_s && !idle_d_q && !idle_seen_q)
				|| (as_zero && !as_load_q))) begin
				save_q <= 1'b1;
			end
			if (routine_q && state_q == ST_IDLE && !rt_load_q && rt_zero) begin
				routine_q <= 1'b0;
				if (routine_test_q) begin
					test_stat_q <= fail_s ? TEST_FAILED : TEST_PASS;
				end
			end
			case (state_q)
				ST_IDLE: begin
					if (cmd_wr) begin
						// The routine pauses while the command is serviced.
						cmd_q <= WB_DAT_IN[7:0];
						state_q <= ST_EXEC;
						busy_q <= 1'b1;
						intrq_q <= 1'b0;
						err_q <= 1'b0;
						abt_q <= 1'b0;
					end
				end
				ST_EXEC: begin
					state_q <= ST_IDLE;
					busy_q <= 1'b0;
					intrq_q <= 1'b1;
					if (cmd_q != CMD_RELIABILITY || (!mon_q && feat_q != SUB_ENABLE)) begin
						err_q <= 1'b1;
						abt_q <= 1'b1;
					end else begin
						case (feat_q)
							SUB_AUTOSAVE: begin
								if (seccnt_q == SC_AS_OFF) begin
									autosave_q <= 1'b0;
								end else if (seccnt_q == SC_AS_ON) begin
									autosave_q <= 1'b1;
								end else begin
									err_q <= 1'b1;
									abt_q <= 1'b1;
								end
							end
							SUB_SAVE: save_q <= 1'b1;
							SUB_EXEC: begin
								rt_load_q <= 1'b1;
								case (secnum_q)
									SN_OFFLINE: begin
										routine_q <= 1'b1;
										routine_test_q <= 1'b0;
										rt_val_q <= TMR_W'(OFFLINE_TICKS_P);
									end
									SN_SHORT_OFF, SN_EXT_OFF: begin
										routine_q <= 1'b1;
										routine_test_q <= 1'b1;
										test_stat_q <= TEST_RUNNING;
										rt_val_q <= secnum_q == SN_SHORT_OFF ?
											TMR_W'(SHORT_TEST_TICKS_P) : TMR_W'(EXT_TEST_TICKS_P);
									end
									SN_ABORT: begin
										rt_load_q <= 1'b0;
										if (routine_q && routine_test_q) begin
											routine_q <= 1'b0;
											test_stat_q <= TEST_ABORTED;
										end
									end
									SN_SHORT_CAP, SN_EXT_CAP: begin
										routine_q <= 1'b0;
										test_stat_q <= TEST_RUNNING;
										rt_val_q <= secnum_q == SN_SHORT_CAP ?
											TMR_W'(SHORT_TEST_TICKS_P) : TMR_W'(EXT_TEST_TICKS_P);
										state_q <= ST_CAPT;
										busy_q <= 1'b1;
										intrq_q <= 1'b0;
									end
									default: begin
										rt_load_q <= 1'b0;
										err_q <= 1'b1;
										abt_q <= 1'b1;
									end
								endcase
							end
							SUB_LOG_RD, SUB_LOG_WR: begin
								log_q <= secnum_q;
								ptr_q <= 9'h000;
								if (seccnt_q != SC_ONE || !log_valid
									|| (feat_q == SUB_LOG_WR && !log_vend)) begin
									err_q <= 1'b1;
									abt_q <= 1'b1;
								end else if (feat_q == SUB_LOG_RD) begin
									state_q <= ST_RDX;
									drq_q <= 1'b1;
								end else begin
									state_q <= ST_WRX;
									drq_q <= 1'b1;
									intrq_q <= 1'b0;
								end
							end
							SUB_ENABLE: mon_q <= 1'b1;
							SUB_DISABLE: begin
								mon_q <= 1'b0;
								autosave_q <= 1'b0;
								routine_q <= 1'b0;
							end
							SUB_STATUS: begin
								save_q <= 1'b1;
								if (prefail_s) begin
									cyllo_q <= CYL_BAD_LO;
									cylhi_q <= CYL_BAD_HI;
								end else begin
									cyllo_q <= CYL_OK_LO;
									cylhi_q <= CYL_OK_HI;
								end
							end
							default: begin
								err_q <= 1'b1;
								abt_q <= 1'b1;
							end
						endcase
					end
				end
				ST_CAPT: begin
					if (!rt_load_q && rt_zero) begin
						state_q <= ST_IDLE;
						busy_q <= 1'b0;
						intrq_q <= 1'b1;
						test_stat_q <= fail_s ? TEST_FAILED : TEST_PASS;
						if (fail_s) begin
							err_q <= 1'b1;
							abt_q <= 1'b1;
							cyllo_q <= CYL_BAD_LO;
							cylhi_q <= CYL_BAD_HI;
						end
					end
				end
				ST_RDX, ST_WRX: begin
					if (dat_acc) begin
						ptr_q <= ptr_q + 1'b1;
						if (ptr_q == PTR_LAST) begin
							state_q <= ST_IDLE;
							drq_q <= 1'b0;
							if (state_q == ST_WRX) begin
								intrq_q <= 1'b1;
							end
						end
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// ====================================================================
	// Outputs
	always_ff @(posedge CLOCK_IN or posedge RST_IN) begin
		if (RST_IN) begin
			INTRQ_OUT <= 1'b0;
			ATTR_SAVE_OUT <= 1'b0;
			MON_EN_OUT <= 1'b0;
			AUTOSAVE_EN_OUT <= 1'b0;
			ROUTINE_RUN_OUT <= 1'b0;
		end else begin
			INTRQ_OUT <= intrq_q;
			ATTR_SAVE_OUT <= save_q;
			MON_EN_OUT <= mon_q;
			AUTOSAVE_EN_OUT <= autosave_q;
			ROUTINE_RUN_OUT <= routine_q || state_q == ST_CAPT;
		end
	end
endmodule

/* src/smh_pkg.sv */
// Package of constants and types for the reliability subcommand handler.
// ====================================================================
package smh_pkg;

	// ====================================================================
	// Timing
	localparam int CLK_HZ = 10_000_000;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
	localparam int AUTOSAVE_MIN = 30;
	localparam int AUTOSAVE_TICKS = AUTOSAVE_MIN * 60 * (1_000_000 / TICK_US);
	localparam int SERVICE_S = 2;
	localparam int SERVICE_CYCLES = SERVICE_S * CLK_HZ;
	localparam int OFFLINE_TICKS = 5000;
	localparam int SHORT_TEST_TICKS = 10000;
	localparam int EXT_TEST_TICKS = 60000;
	localparam int TMR_W = 21;
	localparam int DIV_W = 14;
	localparam int NUM_PINS = 5;
	localparam logic [2:0] NV_LOAD_CYCLE = 3'h4;

	// ====================================================================
	// Register indices; the byte address is four times the index.
	localparam logic [5:0] IDX_DATA = 6'h00;
	localparam logic [5:0] IDX_FEAT = 6'h01;
	localparam logic [5:0] IDX_SECCNT = 6'h02;
	localparam logic [5:0] IDX_SECNUM = 6'h03;
	localparam logic [5:0] IDX_CYLLO = 6'h04;
	localparam logic [5:0] IDX_CYLHI = 6'h05;
	localparam logic [5:0] IDX_DEVHEAD = 6'h06;
	localparam logic [5:0] IDX_CMD = 6'h07;
	localparam logic [5:0] IDX_STATE = 6'h08;
	localparam logic [5:0] IDX_TESTSTAT = 6'h09;
	localparam logic [7:0] RST_TASK = 8'h00;

	// ====================================================================
	// Status and error bit positions
	localparam int BIT_BSY = 7;
	localparam int BIT_RDY = 6;
	localparam int BIT_DSC = 4;
	localparam int BIT_DRQ = 3;
	localparam int BIT_ERR = 0;
	localparam int BIT_ABT = 2;

	// ====================================================================
	// Opcodes, selectors and parameter values
	localparam logic [7:0] CMD_RELIABILITY = 8'hB0;
	localparam logic [7:0] SUB_AUTOSAVE = 8'hD2;
	localparam logic [7:0] SUB_SAVE = 8'hD3;
	localparam logic [7:0] SUB_EXEC = 8'hD4;
	localparam logic [7:0] SUB_LOG_RD = 8'hD5;
	localparam logic [7:0] SUB_LOG_WR = 8'hD6;
	localparam logic [7:0] SUB_ENABLE = 8'hD8;
	localparam logic [7:0] SUB_DISABLE = 8'hD9;
	localparam logic [7:0] SUB_STATUS = 8'hDA;
	localparam logic [7:0] SC_AS_OFF = 8'h00;
	localparam logic [7:0] SC_AS_ON = 8'hF1;
	localparam logic [7:0] SC_ONE = 8'h01;
	localparam logic [7:0] SN_OFFLINE = 8'h00;
	localparam logic [7:0] SN_SHORT_OFF = 8'h01;
	localparam logic [7:0] SN_EXT_OFF = 8'h02;
	localparam logic [7:0] SN_ABORT = 8'h7F;
	localparam logic [7:0] SN_SHORT_CAP = 8'h81;
	localparam logic [7:0] SN_EXT_CAP = 8'h82;
	localparam logic [7:0] LOG_ERROR = 8'h01;
	localparam logic [7:0] LOG_SELFTEST = 8'h06;
	localparam logic [7:0] LOG_VEND_LO = 8'h80;
	localparam logic [7:0] LOG_VEND_HI = 8'h9F;
	localparam logic [8:0] PTR_LAST = 9'h1FF;
	localparam int VEND_BYTES = 32 * 512;
	localparam logic [7:0] CYL_OK_LO = 8'h4F;
	localparam logic [7:0] CYL_OK_HI = 8'hC2;
	localparam logic [7:0] CYL_BAD_LO = 8'hF4;
	localparam logic [7:0] CYL_BAD_HI = 8'h2C;
	localparam logic [7:0] TEST_PASS = 8'h00;
	localparam logic [7:0] TEST_ABORTED = 8'h10;
	localparam logic [7:0] TEST_FAILED = 8'h70;
	localparam logic [7:0] TEST_RUNNING = 8'hF0;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_EXEC = 3'b001,
		ST_CAPT = 3'b011,
		ST_RDX = 3'b010,
		ST_WRX = 3'b110
	} smh_state_type;

endpackage

/* src/smh_sync3.sv */
// Three-stage input synchroniser with agreement filter.
`timescale 1ns/1ps
module smh_sync3 (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic pin_in,
	output logic level_out
);
	logic s1_q;
	logic s2_q;
	logic s3_q;

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_out <= 1'b0;
		end else begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			// A change counts only once the last two stages agree.
			if (s2_q == s3_q) begin
				level_out <= s3_q;
			end
		end
	end
endmodule

/* tb/smh_handler_chk.sv */
// Concurrent checks on the ports of the reliability subcommand handler.
`timescale 1ns/1ps
module smh_handler_chk (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic WB_CYC_IN,
	input wire logic WB_STB_IN,
	input wire logic [31:0] WB_DAT_OUT,
	input wire logic WB_ACK_OUT,
	input wire logic ATTR_SAVE_OUT,
	input wire logic MON_EN_OUT,
	input wire logic AUTOSAVE_EN_OUT,
	input wire logic ROUTINE_RUN_OUT
);
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (RST_IN);
	sequence s_take;
		WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT;
	endsequence
	sequence s_idle_bus;
		!(WB_CYC_IN && WB_STB_IN);
	endsequence
	a_ack_follows_take: assert property (s_take |=> WB_ACK_OUT)
		else $error("ack did not follow a taken request");
	a_ack_single: assert property (WB_ACK_OUT |=> !WB_ACK_OUT)
		else $error("ack held longer than one cycle");
	a_ack_needs_req: assert property (s_idle_bus |=> !WB_ACK_OUT)
		else $error("ack without a request");
	a_dat_high_zero: assert property (WB_DAT_OUT[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	a_save_pulse_short: assert property (ATTR_SAVE_OUT |=> !ATTR_SAVE_OUT)
		else $error("save pulse longer than one cycle");
	a_save_needs_mon: assert property (ATTR_SAVE_OUT |-> $past(MON_EN_OUT))
		else $error("save while monitoring off");
	a_autosave_needs_mon: assert property (AUTOSAVE_EN_OUT |-> MON_EN_OUT)
		else $error("autosave on while monitoring off");
	a_routine_needs_mon: assert property ($rose(ROUTINE_RUN_OUT) |-> MON_EN_OUT)
		else $error("routine started while monitoring off");
endmodule
bind smh_handler smh_handler_chk smh_handler_chk_i (
	.CLOCK_IN(CLOCK_IN),
	.RST_IN(RST_IN),
	.WB_CYC_IN(WB_CYC_IN),
	.WB_STB_IN(WB_STB_IN),
	.WB_DAT_OUT(WB_DAT_OUT),
	.WB_ACK_OUT(WB_ACK_OUT),
	.ATTR_SAVE_OUT(ATTR_SAVE_OUT),
	.MON_EN_OUT(MON_EN_OUT),
	.AUTOSAVE_EN_OUT(AUTOSAVE_EN_OUT),
	.ROUTINE_RUN_OUT(ROUTINE_RUN_OUT)
);

/* tb/smh_handler_tb_top.sv */
// Self-checking testbench for the reliability subcommand handler.
`timescale 1ns/1ps
module smh_handler_tb_top;
	import smh_pkg::*;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic go = 1'b0;
	logic we = 1'b0;
	logic [5:0] idx = 6'h00;
	logic [7:0] wd = 8'h00;
	logic fail = 1'b0;
	logic pref = 1'b0;
	logic aidle = 1'b0;
	logic nv_mon = 1'b0;
	logic nv_as = 1'b0;
	logic [3:0] sel = 4'h1;
	logic [7:0] rdat, v, adr;
	logic done, cyc, wwe, ack, intrq, save, mon, asv, run, irq;
	logic [31:0] dto, dti;
	int num_errors = 0;
	int check_count = 0;
	int saves = 0;
	always #50 clk = ~clk;
	always @(posedge clk) if (save === 1'b1) saves <= saves + 1;
	smh_host_model smh_host_model_i (.clk_in(clk), .go_in(go), .we_in(we), .idx_in(idx),
		.dat_in(wd), .ack_in(ack), .rdat_in(dto), .cyc_out(cyc), .we_out(wwe),
		.adr_out(adr), .dat_out(dti), .done_out(done), .rdat_out(rdat));
	smh_handler #(.TICK_CYCLES_P(4), .AUTOSAVE_TICKS_P(20), .OFFLINE_TICKS_P(10),
		.SHORT_TEST_TICKS_P(5), .EXT_TEST_TICKS_P(30)) smh_handler_i (.CLOCK_IN(clk),
		.RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(cyc), .WB_WE_IN(wwe), .WB_ADR_IN(adr),
		.WB_SEL_IN(sel), .WB_DAT_IN(dti), .WB_DAT_OUT(dto), .WB_ACK_OUT(ack),
		.NV_MON_EN_IN(nv_mon), .NV_AUTOSAVE_IN(nv_as), .ACTIVE_IDLE_IN(aidle),
		.TEST_FAIL_IN(fail), .PREFAIL_EXCEEDED_IN(pref), .INTRQ_OUT(intrq),
		.ATTR_SAVE_OUT(save), .MON_EN_OUT(mon), .AUTOSAVE_EN_OUT(asv),
		.ROUTINE_RUN_OUT(run));
	task automatic results();
		if (num_errors == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
		check_count++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic acc(input logic w, input logic [5:0] i, input logic [7:0] d);
		@(posedge clk);
		we <= w;
		idx <= i;
		wd <= d;
		go <= 1'b1;
		for (int n = 0; n < 20 && done !== 1'b1; n++) @(posedge clk);
		if (done !== 1'b1) chk("bus ack", 8'h01, 8'h00);
		go <= 1'b0;
		v = rdat;
	endtask
	// Polls status until busy clears; the interrupt is sampled before the first status read.
	task automatic cmd(input logic [7:0] f, input logic [7:0] sc, input logic [7:0] sn);
		acc(1'b1, IDX_FEAT, f);
		acc(1'b1, IDX_SECCNT, sc);
		acc(1'b1, IDX_SECNUM, sn);
		acc(1'b1, IDX_CMD, CMD_RELIABILITY);
		repeat (4) @(posedge clk);
		irq = intrq;
		for (int n = 0; n < 40; n++) begin
			acc(1'b0, IDX_CMD, 8'h00);
			if (v[BIT_BSY] === 1'b0) break;
		end
		if (v[BIT_BSY] !== 1'b0) chk("busy", 8'h00, v & 8'h80);
	endtask
	task automatic reg_is(input string name, input logic [5:0] i, input logic [7:0] e);
		acc(1'b0, i, 8'h00);
		chk(name, e, v);
	endtask
	task automatic t_enable();
		cmd(SUB_DISABLE, 8'h00, 8'h00);
		chk("status", 8'h51, v);
		reg_is("error", IDX_FEAT, 8'h04);
		reg_is("unmapped", 6'h20, 8'h00);
		for (int n = 0; n < 2; n++) begin
			cmd(SUB_ENABLE, 8'h00, 8'h00);
			chk("status", 8'h50, v);
			chk("irq", 8'h01, {7'h00, irq});
			chk("mon", 8'h01, {7'h00, mon});
		end
	endtask
	task automatic t_autosave();
		cmd(SUB_AUTOSAVE, 8'h05, 8'h00);
		chk("status", 8'h51, v);
		chk("autosave", 8'h00, {7'h00, asv});
		cmd(SUB_AUTOSAVE, SC_AS_ON, 8'h00);
		chk("irq", 8'h01, {7'h00, irq});
		chk("autosave", 8'h01, {7'h00, asv});
		cmd(SUB_AUTOSAVE, 8'h05, 8'h00);
		chk("autosave", 8'h01, {7'h00, asv});
		saves = 0;
		aidle <= 1'b1;
		repeat (40) @(posedge clk);
		chk("idle saves", 8'h01, 8'(saves));
		repeat (90) @(posedge clk);
		chk("timed saves", 8'h02, 8'(saves));
		cmd(SUB_AUTOSAVE, SC_AS_OFF, 8'h00);
		chk("autosave", 8'h00, {7'h00, asv});
	endtask
	task automatic t_status();
		saves = 0;
		cmd(SUB_SAVE, 8'h00, 8'h00);
		repeat (4) @(posedge clk);
		chk("saves", 8'h01, 8'(saves));
		cmd(SUB_STATUS, 8'h00, 8'h00);
		reg_is("cyl low", IDX_CYLLO, 8'h4F);
		reg_is("cyl high", IDX_CYLHI, 8'hC2);
		chk("saves", 8'h02, 8'(saves));
		pref <= 1'b1;
		repeat (8) @(posedge clk);
		cmd(SUB_STATUS, 8'h00, 8'h00);
		reg_is("cyl low", IDX_CYLLO, 8'hF4);
		reg_is("cyl high", IDX_CYLHI, 8'h2C);
	endtask
	task automatic t_tests();
		// The extended test runs last so that it is still busy when the abort arrives.
		logic [7:0] sns [3] = '{SN_OFFLINE, SN_SHORT_OFF, SN_EXT_OFF};
		fail <= 1'b1;
		repeat (8) @(posedge clk);
		cmd(SUB_EXEC, 8'h00, SN_SHORT_CAP);
		chk("status", 8'h51, v);
		reg_is("error", IDX_FEAT, 8'h04);
		reg_is("cyl low", IDX_CYLLO, 8'hF4);
		reg_is("cyl high", IDX_CYLHI, 8'h2C);
		reg_is("test", IDX_TESTSTAT, TEST_FAILED);
		fail <= 1'b0;
		repeat (8) @(posedge clk);
		cmd(SUB_EXEC, 8'h00, SN_EXT_CAP);
		chk("status", 8'h50, v);
		reg_is("test", IDX_TESTSTAT, TEST_PASS);
		cmd(SUB_EXEC, 8'h00, 8'h03);
		chk("status", 8'h51, v);
		foreach (sns[k]) begin
			cmd(SUB_EXEC, 8'h00, sns[k]);
			chk("status", 8'h50, v);
			chk("run", 8'h01, {7'h00, run});
		end
		cmd(SUB_SAVE, 8'h00, 8'h00);
		chk("status", 8'h50, v);
		chk("run", 8'h01, {7'h00, run});
		cmd(SUB_EXEC, 8'h00, SN_ABORT);
		reg_is("test", IDX_TESTSTAT, TEST_ABORTED);
		chk("run", 8'h00, {7'h00, run});
	endtask
	task automatic t_log();
		cmd(SUB_LOG_WR, SC_ONE, LOG_SELFTEST);
		chk("status", 8'h51, v);
		cmd(SUB_LOG_WR, SC_ONE, LOG_ERROR);
		chk("status", 8'h51, v);
		cmd(SUB_LOG_RD, 8'h02, LOG_VEND_HI);
		chk("status", 8'h51, v);
		cmd(SUB_LOG_WR, SC_ONE, LOG_VEND_HI);
		chk("status", 8'h58, v);
		for (int i = 0; i < 512; i++) acc(1'b1, IDX_DATA, 8'(i) ^ 8'h5A);
		reg_is("status", IDX_CMD, 8'h50);
		cmd(SUB_LOG_RD, SC_ONE, LOG_VEND_HI);
		chk("status", 8'h58, v);
		for (int i = 0; i < 512; i++) reg_is("log", IDX_DATA, 8'(i) ^ 8'h5A);
		reg_is("status", IDX_CMD, 8'h50);
	endtask
	task automatic t_disable();
		cmd(SUB_AUTOSAVE, SC_AS_ON, 8'h00);
		cmd(SUB_DISABLE, 8'h00, 8'h00);
		chk("status", 8'h50, v);
		chk("mon", 8'h00, {7'h00, mon});
		chk("autosave", 8'h00, {7'h00, asv});
		cmd(SUB_SAVE, 8'h00, 8'h00);
		chk("status", 8'h51, v);
		cmd(SUB_ENABLE, 8'h00, 8'h00);
		saves = 0;
		cmd(SUB_SAVE, 8'h00, 8'h00);
		repeat (4) @(posedge clk);
		chk("saves", 8'h01, 8'(saves));
	endtask
	// A second reset restores both enables from the store pins.
	task automatic t_nv();
		@(posedge clk);
		nv_mon <= 1'b1;
		nv_as <= 1'b1;
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		chk("mon", 8'h01, {7'h00, mon});
		chk("autosave", 8'h01, {7'h00, asv});
		reg_is("status", IDX_CMD, 8'h50);
		sel <= 4'h0;
		acc(1'b1, IDX_SECCNT, 8'h33);
		sel <= 4'h1;
		reg_is("sel ignored", IDX_SECCNT, 8'h00);
	endtask
	initial begin
		#3_000_000;
		num_errors++;
		results();
	end
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (8) @(posedge clk);
		t_enable();
		t_autosave();
		t_status();
		t_tests();
		t_log();
		t_disable();
		t_nv();
		results();
	end
endmodule

/* tb/smh_host_model.sv */
// Host model issuing single classic Wishbone task-file accesses.
`timescale 1ns/1ps
module smh_host_model (
	input wire logic clk_in,
	input wire logic go_in,
	input wire logic we_in,
	input wire logic [5:0] idx_in,
	input wire logic [7:0] dat_in,
	input wire logic ack_in,
	input wire logic [31:0] rdat_in,
	output logic cyc_out,
	output logic we_out,
	output logic [7:0] adr_out,
	output logic [31:0] dat_out,
	output logic done_out,
	output logic [7:0] rdat_out
);
	initial begin
		cyc_out = 1'b0;
		we_out = 1'b0;
		adr_out = 8'h00;
		dat_out = 32'h00000000;
		done_out = 1'b0;
		rdat_out = 8'h00;
	end
	// Released address and data lines show the inverse of their last value, so stale data never looks valid.
	always @(posedge clk_in) begin
		done_out <= 1'b0;
		if (cyc_out && ack_in) begin
			cyc_out <= 1'b0;
			adr_out <= ~adr_out;
			dat_out <= ~dat_out;
			rdat_out <= rdat_in[7:0];
			done_out <= 1'b1;
		end else if (!cyc_out && go_in && !done_out) begin
			cyc_out <= 1'b1;
			we_out <= we_in;
			adr_out <= {idx_in, 2'b00};
			dat_out <= {24'h000000, dat_in};
		end
	end
endmodule
